// >>> verilog/amc_pkg.sv
// amc_pkg: constants and types for the converter mode control block.
// assumes: 32-bit apb, one core clock, word-aligned register indices.
`default_nettype none

package amc_pkg;

  localparam int AMC_ADDR_W = 12;
  localparam int AMC_IDX_W = 10;
  localparam int AMC_RES_W = 24;
  localparam int AMC_RES16_W = 16;
  localparam int AMC_SYNC_W = 1;

  // register indices, byte address is four times the index
  localparam logic [9:0] AMC_MODE_IDX_LO = 10'h038;
  localparam logic [9:0] AMC_MODE_IDX_HI = 10'h03F;
  localparam logic [9:0] AMC_STAT_IDX = 10'h040;

  // operating_mode_control field layout
  localparam int AMC_MODE_MSB = 7;
  localparam int AMC_MODE_LSB = 5;
  localparam int AMC_CLOCK_OUTPUT_DISABLE_BIT = 4;
  localparam int AMC_DUMP_BIT = 3;
  localparam int AMC_CONTRD_BIT = 2;
  localparam int AMC_WIDTH_BIT = 1;
  localparam int AMC_CLAMP_BIT = 0;
  localparam int AMC_CHAN_W = 3;
  localparam logic [7:0] AMC_MODE_RESET = 8'h00;

  // status register field layout
  localparam int AMC_ST_STATE_LSB = 0;
  localparam int AMC_ST_CHAN_LSB = 5;
  localparam int AMC_ST_RDYN_BIT = 8;
  localparam int AMC_ST_XTAL_BIT = 9;
  localparam int AMC_ST_CLKEN_BIT = 10;

  typedef enum logic [2:0] {
    AMC_MD_IDLE = 3'h0,
    AMC_MD_CONT = 3'h1,
    AMC_MD_SINGLE = 3'h2,
    AMC_MD_STBY = 3'h3,
    AMC_MD_SELFZ = 3'h4,
    AMC_MD_RSVD = 3'h5,
    AMC_MD_SYSZ = 3'h6,
    AMC_MD_SYSF = 3'h7
  } amc_mode_type;

  typedef enum logic [4:0] {
    AMC_ST_IDLE = 5'h01,
    AMC_ST_RUN = 5'h02,
    AMC_ST_ONE = 5'h04,
    AMC_ST_STBY = 5'h08,
    AMC_ST_CAL = 5'h10
  } amc_state_type;

endpackage : amc_pkg

`default_nettype wire

// >>> verilog/amc_pin_sync.sv
// amc_pin_sync: three-stage synchroniser for pin levels.
// assumes: input is asynchronous to core_clk_in; output moves once
// the second and third stages agree.
`default_nettype none

module amc_pin_sync
  import amc_pkg::*;
#(
  parameter int WIDTH = AMC_SYNC_W
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] lvl_ff;
  logic [WIDTH-1:0] nxt_lvl;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign nxt_lvl[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : lvl_ff[g];
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level_out = lvl_ff;

endmodule : amc_pin_sync

`default_nettype wire

// >>> verilog/amc_result_fmt.sv
// amc_result_fmt: shapes one channel result for the data registers.
// assumes: raw result with over/under range flags, same clock.
`default_nettype none

module amc_result_fmt
  import amc_pkg::*;
#(
  parameter int RES_W = AMC_RES_W,
  parameter int NARROW_W = AMC_RES16_W
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic raw_valid_in,
  input wire logic [RES_W-1:0] raw_in,
  input wire logic over_in,
  input wire logic under_in,
  input wire logic clamp_in,
  input wire logic wide_in,
  output logic [RES_W-1:0] res_out,
  output logic valid_out
);

  logic [RES_W-1:0] res_ff;
  logic valid_ff;
  logic [RES_W-1:0] sat_val;
  logic [RES_W-1:0] nxt_res;

  assign sat_val = (clamp_in && over_in) ? {RES_W{1'b1}} :
                   (clamp_in && under_in) ? {RES_W{1'b0}} :
                   raw_in;
  // narrow results keep the upper bits, zero above
  assign nxt_res = wide_in ? sat_val :
                   {{(RES_W-NARROW_W){1'b0}}, sat_val[RES_W-1 -: NARROW_W]};

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      res_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= raw_valid_in;
      if (raw_valid_in) begin
        res_ff <= nxt_res;
      end
    end
  end

  assign res_out = res_ff;
  assign valid_out = valid_ff;

endmodule : amc_result_fmt

`default_nettype wire

// >>> verilog/amc_mode_ctrl.sv
// amc_mode_ctrl: operating mode register and mode sequencing of a
// multichannel sigma-delta converter, reached over apb.
// assumes: the conversion engine, status flags and data path sit
// outside and report completion with one-cycle pulses on this clock.
`default_nettype none

module amc_mode_ctrl
  import amc_pkg::*;
#(
  parameter int RES_W = AMC_RES_W
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [AMC_ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic conv_done_in,
  input wire logic cal_done_in,
  input wire logic xtal_strap_in,
  input wire logic raw_valid_in,
  input wire logic [RES_W-1:0] raw_result_in,
  input wire logic over_in,
  input wire logic under_in,
  output logic [2:0] mode_select_bits_out,
  output logic [AMC_CHAN_W-1:0] channel_out,
  output logic op_start_out,
  output logic status_clear_out,
  output logic rdy_n_out,
  output logic standby_out,
  output logic calib_out,
  output logic conv_clk_en_out,
  output logic master_clock_output_pin_out,
  output logic master_clock_output_pin_oe_out,
  output logic combined_read_out,
  output logic continuous_read_enable_out,
  output logic width24_out,
  output logic [RES_W-1:0] result_out,
  output logic result_valid_out
);

  ////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] mode_reg_ff;
  logic [7:0] nxt_mode_reg;
  logic [AMC_CHAN_W-1:0] chan_ff;
  logic [AMC_CHAN_W-1:0] nxt_chan;
  amc_state_type state_ff;
  amc_state_type nxt_state;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic start_ff;
  logic clr_ff;
  logic rdy_n_ff;
  logic nxt_rdy_n;
  logic clk_en_ff;
  logic mclk_div_ff;
  logic mclk_oe_ff;
  logic combined_ff;
  logic standby_ff;
  logic calib_ff;
  logic xtal_lvl;

  ////////////////////////////////////////////////////////////////////
  // apb decode

  wire acc = psel_in && penable_in;
  wire acc_first = acc && !pready_ff;
  wire acc_done = acc && pready_ff;
  wire [AMC_IDX_W-1:0] idx = paddr_in[AMC_ADDR_W-1:2];
  wire aligned = (paddr_in[1:0] == 2'h0);
  wire hit_mode_wr = (idx >= AMC_MODE_IDX_LO) && (idx <= AMC_MODE_IDX_HI);
  wire hit_mode_rd = (idx == AMC_MODE_IDX_LO);
  wire hit_stat = (idx == AMC_STAT_IDX);
  wire wr_ok = aligned && hit_mode_wr;
  wire rd_ok = aligned && (hit_mode_rd || hit_stat);
  // refused accesses answer with pslverr and store nothing
  wire acc_bad = pwrite_in ? !wr_ok : !rd_ok;
  wire mode_wr = acc_done && pwrite_in && wr_ok && pstrb_in[0];

  ////////////////////////////////////////////////////////////////////
  // write data fields

  wire [2:0] wr_md_raw = pwdata_in[AMC_MODE_MSB:AMC_MODE_LSB];
  wire wr_rsvd = (wr_md_raw == AMC_MD_RSVD);
  wire [2:0] wr_md = wr_rsvd ? AMC_MD_IDLE : wr_md_raw;
  wire [4:0] wr_flags = pwdata_in[AMC_CLOCK_OUTPUT_DISABLE_BIT:AMC_CLAMP_BIT];
  wire [AMC_CHAN_W-1:0] wr_chan = idx[AMC_CHAN_W-1:0];

  ////////////////////////////////////////////////////////////////////
  // current field views

  wire [2:0] cur_md = mode_reg_ff[AMC_MODE_MSB:AMC_MODE_LSB];
  wire clock_output_disable = mode_reg_ff[AMC_CLOCK_OUTPUT_DISABLE_BIT];
  wire dump = mode_reg_ff[AMC_DUMP_BIT];
  wire continuous_read_enable = mode_reg_ff[AMC_CONTRD_BIT];
  wire wide = mode_reg_ff[AMC_WIDTH_BIT];
  wire clamp = mode_reg_ff[AMC_CLAMP_BIT];

  ////////////////////////////////////////////////////////////////////
  // completion events

  wire conv_state = (state_ff == AMC_ST_RUN) || (state_ff == AMC_ST_ONE);
  wire conv_evt = conv_done_in && conv_state && clk_en_ff;
  wire cal_evt = cal_done_in && (state_ff == AMC_ST_CAL) && clk_en_ff;
  wire one_shot_end = (conv_evt && state_ff == AMC_ST_ONE) || cal_evt;
  wire any_evt = conv_evt || cal_evt;

  ////////////////////////////////////////////////////////////////////
  // mode to state mapping

  function automatic amc_state_type md_to_state(input logic [2:0] md);
    amc_state_type st;
    st = AMC_ST_IDLE;
    unique case (md)
      AMC_MD_IDLE: st = AMC_ST_IDLE;
      AMC_MD_CONT: st = AMC_ST_RUN;
      AMC_MD_SINGLE: st = AMC_ST_ONE;
      AMC_MD_STBY: st = AMC_ST_STBY;
      AMC_MD_SELFZ: st = AMC_ST_CAL;
      AMC_MD_RSVD: st = AMC_ST_IDLE;
      AMC_MD_SYSZ: st = AMC_ST_CAL;
      AMC_MD_SYSF: st = AMC_ST_CAL;
    endcase
    return st;
  endfunction : md_to_state

  ////////////////////////////////////////////////////////////////////
  // next mode register, channel and state

  // a write in the same cycle as a completion wins: the completion
  // belongs to the operation that the write aborts
  always_comb begin
    nxt_mode_reg = mode_reg_ff;
    nxt_chan = chan_ff;
    nxt_state = state_ff;
    if (mode_wr) begin
      nxt_mode_reg = {wr_md, wr_flags};
      nxt_chan = wr_chan;
      nxt_state = md_to_state(wr_md);
    end else if (one_shot_end) begin
      nxt_mode_reg[AMC_MODE_MSB:AMC_MODE_LSB] = AMC_MD_IDLE;
      nxt_state = AMC_ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mode_reg_ff <= AMC_MODE_RESET;
      chan_ff <= '0;
      state_ff <= AMC_ST_IDLE;
    end else begin
      mode_reg_ff <= nxt_mode_reg;
      chan_ff <= nxt_chan;
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state decode for the standby and calibration outputs

  // decoded from the next state so that the registered outputs move
  // on the same edge as the state itself
  wire nxt_standby = (nxt_state == AMC_ST_STBY);
  wire nxt_calib = (nxt_state == AMC_ST_CAL);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      standby_ff <= 1'b0;
      calib_ff <= 1'b0;
    end else begin
      standby_ff <= nxt_standby;
      calib_ff <= nxt_calib;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // start, status clear and ready pin

  always_comb begin
    nxt_rdy_n = rdy_n_ff;
    if (mode_wr) begin
      nxt_rdy_n = 1'b1;
    end else if (any_evt) begin
      nxt_rdy_n = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      start_ff <= 1'b0;
      clr_ff <= 1'b0;
      rdy_n_ff <= 1'b1;
    end else begin
      start_ff <= mode_wr;
      clr_ff <= mode_wr;
      rdy_n_ff <= nxt_rdy_n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clocking: output pin and conversion clock gate

  // the strap is a pin level from outside the core clock domain
  amc_pin_sync #(
    .WIDTH(AMC_SYNC_W)
  ) u_xtal_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(xtal_strap_in),
    .level_out(xtal_lvl)
  );

  // a crystal needs the output pin driven to oscillate
  wire nxt_clk_en = !(clock_output_disable && xtal_lvl);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      clk_en_ff <= 1'b1;
      mclk_div_ff <= 1'b0;
      mclk_oe_ff <= 1'b1;
    end else begin
      clk_en_ff <= nxt_clk_en;
      mclk_oe_ff <= !clock_output_disable;
      if (nxt_clk_en) begin
        mclk_div_ff <= !mclk_div_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read format controls

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      combined_ff <= 1'b0;
    end else begin
      combined_ff <= dump || continuous_read_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb answer, one wait state; the bus side never sees the
  // conversion clock gate, so access goes on while it is stopped

  wire [31:0] stat_word = {
    21'h00000,
    clk_en_ff,
    xtal_lvl,
    rdy_n_ff,
    chan_ff,
    state_ff
  };
  wire [31:0] mode_word = {24'h000000, mode_reg_ff};
  wire [31:0] rd_word = !rd_ok ? 32'h00000000 :
                        hit_stat ? stat_word : mode_word;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc_first;
      pslverr_ff <= acc_first && acc_bad;
      if (acc_first && !pwrite_in) begin
        prdata_ff <= rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // result shaping

  amc_result_fmt #(
    .RES_W(RES_W),
    .NARROW_W(AMC_RES16_W)
  ) u_fmt (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .raw_valid_in(raw_valid_in),
    .raw_in(raw_result_in),
    .over_in(over_in),
    .under_in(under_in),
    .clamp_in(clamp),
    .wide_in(wide),
    .res_out(result_out),
    .valid_out(result_valid_out)
  );

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign prdata_out = prdata_ff;
  assign mode_select_bits_out = cur_md;
  assign channel_out = chan_ff;
  assign op_start_out = start_ff;
  assign status_clear_out = clr_ff;
  assign rdy_n_out = rdy_n_ff;
  assign standby_out = standby_ff;
  assign calib_out = calib_ff;
  assign conv_clk_en_out = clk_en_ff;
  assign master_clock_output_pin_out = mclk_div_ff;
  assign master_clock_output_pin_oe_out = mclk_oe_ff;
  assign combined_read_out = combined_ff;
  assign continuous_read_enable_out = continuous_read_enable;
  assign width24_out = wide;

endmodule : amc_mode_ctrl

`default_nettype wire

// >>> verif/amc_mode_ctrl_asserts.sv
// amc_mode_ctrl_asserts: port-level checks of amc_mode_ctrl.
// assumes: bound to amc_mode_ctrl, one clock, sync active-low reset.
`default_nettype none
module amc_mode_ctrl_asserts
  import amc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [AMC_ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic conv_done_in,
  input wire logic cal_done_in,
  input wire logic [2:0] mode_select_bits_out,
  input wire logic op_start_out,
  input wire logic status_clear_out,
  input wire logic rdy_n_out,
  input wire logic conv_clk_en_out,
  input wire logic master_clock_output_pin_oe_out
);
  wire logic wr = psel_in && penable_in && pready_out && pwrite_in;
  wire logic wr_ok = wr && !pslverr_out && pstrb_in[0];
  wire logic [2:0] md = mode_select_bits_out;
  wire logic ok = conv_clk_en_out && !wr;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  start_clear_a: assert property (op_start_out |-> status_clear_out && rdy_n_out)
    else $error("start without status clear");
  write_start_a: assert property (wr_ok |=> op_start_out)
    else $error("mode write did not start");
  single_done_a: assert property (md == 3'h2 && conv_done_in && ok |=> md == 3'h0 && !rdy_n_out)
    else $error("single not finished");
  cal_done_a: assert property (md[2] && cal_done_in && ok |=> md == 3'h0 && !rdy_n_out)
    else $error("calibration not finished");
  cont_stay_a: assert property (md == 3'h1 && conv_done_in && ok |=> md == 3'h1 && !rdy_n_out)
    else $error("continuous left");
  apb_wait_a: assert property (psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out)
    else $error("wait state wrong");
  bad_read_a: assert property (pready_out && psel_in && !pwrite_in && paddr_in != 12'h0E0 &&
    paddr_in != 12'h100 |-> pslverr_out)
    else $error("bad read accepted");
  oe_off_a: assert property (wr_ok && pwdata_in[4] |-> ##[1:2] !master_clock_output_pin_oe_out)
    else $error("clock pin still driven");
  cover property (wr_ok && pwdata_in[7:5] == 3'h2);
  cover property (md == 3'h2 && conv_done_in && ok);
  cover property (pready_out && pslverr_out);
endmodule : amc_mode_ctrl_asserts
////////////////////////////////////////
bind amc_mode_ctrl amc_mode_ctrl_asserts u_chk (.core_clk_in, .rst_n_in, .paddr_in, .psel_in,
  .penable_in, .pwrite_in, .pwdata_in, .pstrb_in, .pready_out, .pslverr_out, .conv_done_in,
  .cal_done_in, .mode_select_bits_out, .op_start_out, .status_clear_out, .rdy_n_out,
  .conv_clk_en_out, .master_clock_output_pin_oe_out);
`default_nettype wire

// >>> verif/amc_mode_ctrl_bench.sv
// amc_mode_ctrl_bench: self-checking bench for amc_mode_ctrl.
// assumes: bench drives apb and engine pins itself, 40 MHz clock.
`default_nettype none
module amc_mode_ctrl_bench
  import amc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = '0, rst_n = '0, ps = '0, pe = '0, pw = '0, cd = '0, kd = '0;
  logic xt = '0, rv = '0, ov = '0, un = '0, e, cal, act, mk0;
  logic [11:0] pa = '0;
  logic [31:0] pd = '0, r;
  logic [3:0] pb = '0;
  logic [23:0] rr = '0, x;
  logic [7:0] eb;
  wire logic rdy, err, ce, oe, cr, cre, w24, rn, rvo, sb, cb, mk;
  wire logic [31:0] rd;
  wire logic [2:0] md, ch;
  wire logic [23:0] res;
  int err_total = 0, checks = 0, c;
  amc_mode_ctrl dut (.core_clk_in(clk), .rst_n_in(rst_n), .paddr_in(pa), .psel_in(ps),
    .penable_in(pe), .pwrite_in(pw), .pwdata_in(pd), .pstrb_in(pb), .pready_out(rdy),
    .prdata_out(rd), .pslverr_out(err), .conv_done_in(cd), .cal_done_in(kd),
    .xtal_strap_in(xt), .raw_valid_in(rv), .raw_result_in(rr), .over_in(ov), .under_in(un),
    .mode_select_bits_out(md), .channel_out(ch), .op_start_out(), .status_clear_out(),
    .rdy_n_out(rn), .standby_out(sb), .calib_out(cb), .conv_clk_en_out(ce),
    .master_clock_output_pin_out(mk), .master_clock_output_pin_oe_out(oe),
    .combined_read_out(cr), .continuous_read_enable_out(cre), .width24_out(w24),
    .result_out(res), .result_valid_out(rvo));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] v);
    checks++;
    if (g !== v) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, g, v);
    end
  endtask : cmp
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
    input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    ps <= 1'h1;
    pa <= a;
    pw <= w;
    pd <= {24'h0, d};
    pb <= b;
    @(posedge clk);
    pe <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'h1 && n < 20);
    if (n >= 20) err_total++;
    r = rd;
    e = err;
    ps <= 1'h0;
    pe <= 1'h0;
  endtask : apb
  task automatic wm(input int k, input logic [7:0] d);
    apb(12'h0E0 + 12'(k * 4), 1'h1, d, 4'hF);
    eb = d;
    if (d[7:5] == 3'h5) eb[7:5] = 3'h0;
    #1;
  endtask : wm
  task automatic pulse(input logic k);
    @(posedge clk);
    kd <= k;
    cd <= !k;
    @(posedge clk);
    kd <= 1'h0;
    cd <= 1'h0;
    #1;
  endtask : pulse
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////
  initial begin
    #500000;
    err_total++;
    end_sim();
  end
  initial begin
    void'($urandom(30));
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    cmp({md, rn, oe, ce, cr}, 32'h0E);
    apb(12'h0E0, 1'h0, 8'h00, 4'hF);
    cmp(r, 32'h0);
    $display("reset test done");
    for (int m = 0; m < 8; m++) begin
      c = $urandom % 8;
      cal = m >= 4 && m != 5;
      act = m == 1 || m == 2 || cal;
      wm(c, {3'(m), 5'h00});
      cmp({md, ch, rn}, {eb[7:5], 3'(c), 1'h1});
      cmp({sb, cb}, {eb[7:5] == 3'h3, cal});
      apb(12'h100, 1'h0, 8'h00, 4'hF);
      cmp(r[8:0], {1'h1, 3'(c), eb[7:5] > 3 ? 5'h10 : 5'h01 << eb[7:5]});
      pulse(cal);
      if (m == 2 || cal) eb[7:5] = 3'h0;
      cmp({md, rn, sb, cb}, {eb[7:5], !act, eb[7:5] == 3'h3, 1'h0});
      apb(12'h0E0, 1'h0, 8'h00, 4'hF);
      cmp(r, {24'h0, eb});
    end
    $display("mode test done");
    wm(3, 8'hE0);
    wm(6, 8'h20);
    pulse(1'h1);
    cmp({md, ch}, 32'h0E);
    $display("abort test done");
    @(posedge clk);
    xt <= 1'h1;
    wm(2, 8'h5F);
    repeat (6) @(posedge clk);
    #1;
    cmp({cre, w24, cr, oe, ce}, 32'h1C);
    mk0 = mk;
    @(posedge clk);
    #1;
    cmp(mk, mk0);
    pulse(1'h0);
    cmp(md, 32'h2);
    apb(12'h0E0, 1'h0, 8'h00, 4'hF);
    cmp(r, 32'h5F);
    @(posedge clk);
    xt <= 1'h0;
    repeat (6) @(posedge clk);
    #1;
    cmp(ce, 32'h1);
    mk0 = mk;
    @(posedge clk);
    #1;
    cmp(mk, !mk0);
    pulse(1'h0);
    cmp(md, 32'h0);
    wm(0, 8'h04);
    repeat (2) @(posedge clk);
    #1;
    cmp(cr, 32'h1);
    wm(0, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    cmp(cr, 32'h0);
    $display("clock test done");
    for (int k = 0; k < 16; k++) begin
      if (k % 4 == 0) wm(0, {6'h00, 2'(k >> 2)});
      @(posedge clk);
      rv <= 1'h1;
      rr <= 24'($urandom);
      ov <= 1'($urandom);
      un <= 1'($urandom);
      @(posedge clk);
      rv <= 1'h0;
      #1;
      x = rr;
      if (k[2] && ov) x = 24'hFFFFFF;
      else if (k[2] && un) x = 24'h0;
      if (!k[3]) x = x >> 8;
      cmp({rvo, res}, {1'h1, x});
    end
    $display("result test done");
    apb(12'h0E4, 1'h0, 8'h00, 4'hF);
    cmp({e, r[30:0]}, 32'h80000000);
    apb(12'h0DC, 1'h1, 8'h20, 4'hF);
    cmp(e, 32'h1);
    apb(12'h0E0, 1'h1, 8'h20, 4'hE);
    apb(12'h0E0, 1'h0, 8'h00, 4'hF);
    cmp(r, {24'h0, eb});
    wm(7, 8'h60);
    cmp({md, ch}, 32'h1F);
    $display("refusal test done");
    end_sim();
  end
endmodule : amc_mode_ctrl_bench
`default_nettype wire
